/* logic/vefe_regs.vh */
// register map, field positions and reset values of the encoder front end
`ifndef VEFE_REGS_VH
`define VEFE_REGS_VH

`define VEFE_ADDR_EMPH_ZERO   8'h0B
`define VEFE_ADDR_EMPH_POLE   8'h0C
`define VEFE_ADDR_CLP_BW      8'h0E
`define VEFE_ADDR_CLP_PEAK    8'h0F
`define VEFE_ADDR_BLUE_GAIN   8'h11
`define VEFE_ADDR_RED_GAIN    8'h12
`define VEFE_ADDR_OUT_BLANK   8'h25
`define VEFE_ADDR_IN_SYNC     8'h28
`define VEFE_ADDR_BLANK_START 8'h2A
`define VEFE_ADDR_BLANK_END   8'h2B
`define VEFE_ADDR_STANDARD    8'h2C

`define VEFE_BIT_YUV_SEL      0
`define VEFE_BIT_CSYNC_SEL    1
`define VEFE_BIT_VS_BLANK_SEL 2
`define VEFE_BIT_ENC_BLANK_D  0
`define VEFE_BIT_PED_DIS      1
`define VEFE_BIT_SECAM        0

`define VEFE_RST_EMPH_ZERO    8'h00
`define VEFE_RST_EMPH_POLE    8'h00
`define VEFE_RST_CLP_BW       8'h00
`define VEFE_RST_CLP_PEAK     8'h00
`define VEFE_RST_GAIN         8'h40
`define VEFE_RST_CTRL         8'h00
`define VEFE_RST_BLANK_START  8'hE0
`define VEFE_RST_BLANK_END    8'h10

`define VEFE_PEDESTAL         8'h10
`define VEFE_SER_BITS         5'h10

`endif

/* logic/vefe_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module vefe_fifo #(
	parameter WIDTH = 59,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             i_clk,
	input  wire             i_reset_n,
	input  wire [WIDTH-1:0] i_data,
	input  wire             i_valid,
	output wire             o_ready,
	output reg  [WIDTH-1:0] o_data,
	output wire             o_valid,
	input  wire             i_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;

	assign full    = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty   = (wr_ptr == rd_ptr);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign push    = i_valid && !full;
	assign pop     = i_ready && !empty;

	always @(posedge i_clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_data;
	end

	always @* begin
		o_data = mem[rd_ptr[AW-1:0]];
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

/* logic/vefe_front_end.v */
// input colour front end of the video encoder: sync, blanking, chroma filters
`timescale 1ns/100ps
`include "vefe_regs.vh"
module vefe_front_end #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire        i_ser_clk,
	input  wire        i_ser_data,
	input  wire        i_ser_ident,
	input  wire [7:0]  i_pix_a,
	input  wire [7:0]  i_pix_b,
	input  wire [7:0]  i_pix_c,
	input  wire        i_hsync,
	input  wire        i_vsync,
	input  wire        i_pix_valid,
	output wire        o_pix_ready,
	output wire [7:0]  o_dac_a,
	output wire [7:0]  o_dac_b,
	output wire [7:0]  o_dac_c,
	output wire [9:0]  o_u,
	output wire [9:0]  o_v,
	output wire [11:0] o_chroma,
	output wire        o_hsync,
	output wire        o_vsync,
	output wire        o_enc_blank,
	output wire        o_out_valid,
	input  wire        i_out_ready
);
	localparam FW = 59;

	// serial control bus; pins are asynchronous, two flops each
	reg  [2:0]  ser_meta;
	reg  [2:0]  ser_sync;
	reg         ser_clk_d;
	reg         ser_ident_d;
	reg  [15:0] ser_shift;
	reg  [4:0]  ser_count;
	wire        ser_rise;
	wire        ser_end;

	reg  [7:0]  emphasis_zero_coefficient;
	reg  [7:0]  emphasis_pole_coefficient;
	reg  [7:0]  chroma_lowpass_bandwidth;
	reg  [7:0]  chroma_lowpass_peaking;
	reg  [7:0]  blue_difference_gain;
	reg  [7:0]  red_difference_gain;
	reg  [7:0]  output_blanking_control;
	reg  [7:0]  input_sync_control;
	reg  [7:0]  blank_start;
	reg  [7:0]  blank_end;
	reg  [7:0]  standard_control;

	wire color_difference_input_select = input_sync_control[`VEFE_BIT_YUV_SEL];
	wire composite_sync_select = input_sync_control[`VEFE_BIT_CSYNC_SEL];
	wire vsync_as_blank_select = input_sync_control[`VEFE_BIT_VS_BLANK_SEL];
	wire encoder_blank_disable = output_blanking_control[`VEFE_BIT_ENC_BLANK_D];
	wire rgb_pedestal_disable = output_blanking_control[`VEFE_BIT_PED_DIS];
	wire secam_mode = standard_control[`VEFE_BIT_SECAM];

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ser_meta <= 3'h0;
			ser_sync <= 3'h0;
			ser_clk_d <= 1'b0;
			ser_ident_d <= 1'b0;
		end else begin
			ser_meta <= {i_ser_ident, i_ser_data, i_ser_clk};
			ser_sync <= ser_meta;
			ser_clk_d <= ser_sync[0];
			ser_ident_d <= ser_sync[2];
		end
	end

	assign ser_rise = ser_sync[0] && !ser_clk_d;
	// a falling ident edge closes the frame: address byte then data byte
	assign ser_end = !ser_sync[2] && ser_ident_d;

	// count sticks at its top so an overlong frame cannot alias back to sixteen bits
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ser_shift <= 16'h0000;
			ser_count <= 5'h00;
		end else if (ser_end) begin
			ser_count <= 5'h00;
		end else if (ser_rise) begin
			ser_shift <= {ser_shift[14:0], ser_sync[1]};
			if (ser_count != 5'h1F)
				ser_count <= ser_count + 5'h01;
		end
	end

	// frames of any other length are dropped rather than half applied
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			emphasis_zero_coefficient <= `VEFE_RST_EMPH_ZERO;
			emphasis_pole_coefficient <= `VEFE_RST_EMPH_POLE;
			chroma_lowpass_bandwidth <= `VEFE_RST_CLP_BW;
			chroma_lowpass_peaking <= `VEFE_RST_CLP_PEAK;
			blue_difference_gain <= `VEFE_RST_GAIN;
			red_difference_gain <= `VEFE_RST_GAIN;
			output_blanking_control <= `VEFE_RST_CTRL;
			input_sync_control <= `VEFE_RST_CTRL;
			blank_start <= `VEFE_RST_BLANK_START;
			blank_end <= `VEFE_RST_BLANK_END;
			standard_control <= `VEFE_RST_CTRL;
		end else if (ser_end && ser_count == `VEFE_SER_BITS) begin
			case (ser_shift[15:8])
			`VEFE_ADDR_EMPH_ZERO:   emphasis_zero_coefficient <= ser_shift[7:0];
			`VEFE_ADDR_EMPH_POLE:   emphasis_pole_coefficient <= ser_shift[7:0];
			`VEFE_ADDR_CLP_BW:      chroma_lowpass_bandwidth <= ser_shift[7:0];
			`VEFE_ADDR_CLP_PEAK:    chroma_lowpass_peaking <= ser_shift[7:0];
			`VEFE_ADDR_BLUE_GAIN:   blue_difference_gain <= ser_shift[7:0];
			`VEFE_ADDR_RED_GAIN:    red_difference_gain <= ser_shift[7:0];
			`VEFE_ADDR_OUT_BLANK:   output_blanking_control <= ser_shift[7:0];
			`VEFE_ADDR_IN_SYNC:     input_sync_control <= ser_shift[7:0];
			`VEFE_ADDR_BLANK_START: blank_start <= ser_shift[7:0];
			`VEFE_ADDR_BLANK_END:   blank_end <= ser_shift[7:0];
			`VEFE_ADDR_STANDARD:    standard_control <= ser_shift[7:0];
			default: ;
			endcase
		end
	end

	// a loaded pipeline stage holds while the fifo is full, stalling the source
	reg            st_valid;
	wire           fifo_ready;
	wire           advance = !st_valid || fifo_ready;
	wire           accept = i_pix_valid && advance;
	assign o_pix_ready = advance;

	// sync interpretation and line position
	reg        hs_d;
	reg [10:0] hpos;
	reg        line_odd;
	reg        phase;
	wire       line_start = i_hsync && !hs_d;
	wire       vs_is_blank = composite_sync_select || vsync_as_blank_select;
	wire       ext_blank = vs_is_blank && i_vsync;
	wire       vsync_eff = !vs_is_blank && i_vsync;
	wire       int_blank = (hpos >= {blank_start, 3'h0}) || (hpos < {blank_end, 3'h0});
	wire       enc_blank = encoder_blank_disable ? int_blank : ext_blank;

	// hpos holds at its top value, inside the blanking window, so a lost hsync cannot wrap back into active video
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hs_d <= 1'b0;
			hpos <= 11'h000;
			line_odd <= 1'b0;
			phase <= 1'b0;
		end else if (accept) begin
			hs_d <= i_hsync;
			phase <= !phase;
			if (line_start) begin
				hpos <= 11'h000;
				line_odd <= !line_odd;
			end else if (hpos != 11'h7FF) begin
				hpos <= hpos + 11'h001;
			end
		end
	end

	// rgb dac path
	function [7:0] ped_add;
		input [7:0] v;
		input       blank;
		input       dis;
		reg   [8:0] s;
		begin
			s = {1'b0, v} + {1'b0, `VEFE_PEDESTAL};
			if (blank)
				ped_add = 8'h00;
			else if (dis)
				ped_add = v;
			else
				ped_add = s[8] ? 8'hFF : s[7:0];
		end
	endfunction

	// yuv and rgb both land on the same three dacs
	wire [7:0] dac_a = ped_add(i_pix_a, ext_blank, rgb_pedestal_disable);
	wire [7:0] dac_b = ped_add(i_pix_b, ext_blank, rgb_pedestal_disable);
	wire [7:0] dac_c = ped_add(i_pix_c, ext_blank, rgb_pedestal_disable);

	// colour matrix; luma weights sum to 256
	wire [15:0] luma_sum = 16'd77 * {8'h00, i_pix_a} + 16'd150 * {8'h00, i_pix_b}
		+ 16'd29 * {8'h00, i_pix_c};
	wire [7:0]  luma = luma_sum[15:8];
	wire [9:0]  mat_by = {2'b00, i_pix_c} - {2'b00, luma};
	wire [9:0]  mat_ry = {2'b00, i_pix_a} - {2'b00, luma};
	wire [9:0]  yuv_u = {2'b00, i_pix_b} - 10'h080;
	wire [9:0]  yuv_v = {2'b00, i_pix_c} - 10'h080;
	wire [19:0] ch_in = color_difference_input_select ?
		{yuv_v, yuv_u} : {mat_ry, mat_by};

	function [9:0] sat10;
		input signed [20:0] v;
		begin
			if (v > 21'sd511)
				sat10 = 10'h1FF;
			else if (v < -21'sd512)
				sat10 = 10'h200;
			else
				sat10 = v[9:0];
		end
	endfunction

	// per channel: 0 is b-y to u, 1 is r-y to v
	wire [19:0] ch_out;
	wire [15:0] gains = {red_difference_gain, blue_difference_gain};
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			reg  signed [15:0] lp_st;
			wire signed [9:0]  x = ch_in[ch*10 +: 10];
			wire signed [15:0] xs = {x, 6'h00};
			wire signed [16:0] dif = {xs[15], xs} - {lp_st[15], lp_st};
			wire signed [16:0] step = dif >>> chroma_lowpass_bandwidth[2:0];
			wire signed [9:0]  lp = lp_st[15:6];
			wire signed [8:0]  pk = {chroma_lowpass_peaking[7], chroma_lowpass_peaking};
			wire signed [8:0]  dc_k = 9'sd128 + pk;
			wire signed [10:0] hf = {x[9], x} - {lp[9], lp};
			wire signed [20:0] dc_p = dc_k * lp;
			wire signed [20:0] hf_p = (-pk) * hf;
			wire signed [20:0] pk_sum = (dc_p >>> 7) + (hf_p >>> 6);
			wire signed [9:0]  peaked = sat10(pk_sum);
			wire signed [9:0]  gain = {2'b00, gains[ch*8 +: 8]};
			wire signed [20:0] g_p = peaked * gain;
			assign ch_out[ch*10 +: 10] = sat10(g_p >>> 7);
			// the word carries the state held before this sample's update
			always @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n)
					lp_st <= 16'h0000;
				else if (accept)
					lp_st <= lp_st + step[15:0];
			end
		end
	endgenerate

	// secam preemphasis on the lowpass output, at half rate
	reg  signed [9:0]  px [0:3];
	reg  signed [11:0] py [0:3];
	reg  signed [11:0] emph_out;
	wire signed [9:0]  lp_u = g_chan[0].peaked;
	wire signed [9:0]  lp_v = g_chan[1].peaked;
	wire signed [9:0]  px_in = line_odd ? lp_v : sat10(-{{11{lp_u[9]}}, lp_u});
	wire signed [8:0]  coef_a = {2'b00, emphasis_zero_coefficient[6:0]};
	wire signed [8:0]  coef_b = {3'b000, emphasis_pole_coefficient[5:0]};
	wire signed [18:0] a_p = px[3] * coef_a;
	wire signed [20:0] b_p = py[3] * coef_b;
	// the delayed product keeps its sign through the rescaling shift
	wire signed [13:0] w = {{4{px_in[9]}}, px_in} - {{2{a_p[18]}}, a_p[18:7]};
	wire signed [20:0] y_full = {{5{w[13]}}, w, 2'b00} + (b_p >>> 6);
	wire signed [11:0] y_sat = (y_full > 21'sd2047) ? 12'h7FF :
		(y_full < -21'sd2048) ? 12'h800 : y_full[11:0];
	integer k;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (k = 0; k < 4; k = k + 1) begin
				px[k] <= 10'h000;
				py[k] <= 12'h000;
			end
			emph_out <= 12'h000;
		end else if (accept && phase && secam_mode) begin
			for (k = 3; k > 0; k = k - 1) begin
				px[k] <= px[k-1];
				py[k] <= py[k-1];
			end
			px[0] <= px_in;
			py[0] <= y_sat;
			emph_out <= y_sat;
		end
	end

	// bypass passes the line-sequential chroma unchanged
	wire [11:0] chroma = secam_mode ? emph_out : {{2{px_in[9]}}, px_in};

	// output stage feeding the fifo
	// the stage register gives one word of slack beyond the fifo depth
	reg [FW-1:0] st_word;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_valid <= 1'b0;
			st_word <= {FW{1'b0}};
		end else if (advance) begin
			st_valid <= i_pix_valid;
			if (i_pix_valid)
				st_word <= {dac_a, dac_b, dac_c, ch_out[9:0], ch_out[19:10], chroma,
					i_hsync, vsync_eff, enc_blank};
		end
	end

	wire [FW-1:0] out_word;

	vefe_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_data    (st_word),
		.i_valid   (st_valid),
		.o_ready   (fifo_ready),
		.o_data    (out_word),
		.o_valid   (o_out_valid),
		.i_ready   (i_out_ready)
	);

	// word layout: three dac codes, u, v, chroma, then sync and blank flags
	assign o_dac_a     = out_word[58:51];
	assign o_dac_b     = out_word[50:43];
	assign o_dac_c     = out_word[42:35];
	assign o_u         = out_word[34:25];
	assign o_v         = out_word[24:15];
	assign o_chroma    = out_word[14:3];
	assign o_hsync     = out_word[2];
	assign o_vsync     = out_word[1];
	assign o_enc_blank = out_word[0];
endmodule

/* bench/vefe_pix_source.sv */
// pixel source model that feeds samples and syncs into the front end
`timescale 1ns/100ps
module vefe_pix_source (
	input  logic       i_clk,
	input  logic       i_ready,
	output logic [7:0] o_a,
	output logic [7:0] o_b,
	output logic [7:0] o_c,
	output logic       o_hs,
	output logic       o_vs,
	output logic       o_valid
);
	initial begin
		{o_a, o_b, o_c, o_hs, o_vs, o_valid} = '0;
	end
	// entered 1 ns after an edge, returns 1 ns after the edge that took the sample
	task automatic send(input logic [7:0] a, b, c, input logic hs, vs);
		{o_a, o_b, o_c, o_hs, o_vs, o_valid} = {a, b, c, hs, vs, 1'b1};
		#2;
		while (i_ready !== 1'b1) begin
			@(posedge i_clk);
			#3;
		end
		@(posedge i_clk);
		#1;
	endtask
	// idle data carries no meaning, so it must not look like the last sample
	task automatic idle();
		o_valid = 1'b0;
		{o_a, o_b, o_c} = ~{o_a, o_b, o_c};
	endtask
endmodule

/* bench/vefe_front_end_properties.sv */
// port assertions for the encoder front end, with a shadow of the serial settings
`timescale 1ns/100ps
module vefe_front_end_properties (
	input logic       i_clk,
	input logic       i_reset_n,
	input logic       i_ser_clk,
	input logic       i_ser_data,
	input logic       i_ser_ident,
	input logic       i_pix_valid,
	input logic       o_pix_ready,
	input logic [7:0] o_dac_a,
	input logic [7:0] o_dac_b,
	input logic [7:0] o_dac_c,
	input logic [9:0] o_u,
	input logic [9:0] o_v,
	input logic       o_vsync,
	input logic       o_enc_blank,
	input logic       o_out_valid,
	input logic       i_out_ready
);
	logic [15:0] sh;
	logic [4:0]  n;
	logic        sc, id;
	logic [7:0]  gain_u, gain_v, blank_ctl, sync_ctl;
	wire         ext_mode = sync_ctl[1] | sync_ctl[2];
	wire [23:0]  dacs = {o_dac_a, o_dac_b, o_dac_c};
	// shadow lands before the design applies a write; the bench idles across writes
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{sh, n, sc, id, blank_ctl, sync_ctl} <= '0;
			{gain_u, gain_v} <= 16'h4040;
		end else begin
			sc <= i_ser_clk;
			id <= i_ser_ident;
			if (i_ser_clk && !sc) begin
				sh <= {sh[14:0], i_ser_data};
				n <= n + 5'h01;
			end
			if (id && !i_ser_ident) begin
				n <= 5'h00;
				if (n == 5'h10 && sh[15:8] == 8'h11) gain_u <= sh[7:0];
				if (n == 5'h10 && sh[15:8] == 8'h12) gain_v <= sh[7:0];
				if (n == 5'h10 && sh[15:8] == 8'h25) blank_ctl <= sh[7:0];
				if (n == 5'h10 && sh[15:8] == 8'h28) sync_ctl <= sh[7:0];
			end
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_take;
		i_pix_valid && o_pix_ready;
	endsequence
	sequence s_stall;
		o_out_valid && !i_out_ready;
	endsequence
	a_take_to_word: assert property (s_take |-> ##[1:3] o_out_valid)
		else $error("taken sample did not reach the output");
	a_word_holds: assert property (s_stall |=> o_out_valid && $stable({dacs, o_u, o_v}))
		else $error("output word changed while stalled");
	a_refuse_full: assert property (!o_pix_ready |-> o_out_valid)
		else $error("input refused with an empty buffer");
	a_blank_zeroes: assert property (o_out_valid && !blank_ctl[0] && o_enc_blank |-> dacs == 24'h0)
		else $error("blanked word has nonzero dac codes");
	a_pedestal_floor: assert property (o_out_valid && blank_ctl[1:0] == 2'b00 && !o_enc_blank
		|-> o_dac_a >= 8'h10 && o_dac_b >= 8'h10 && o_dac_c >= 8'h10)
		else $error("active word lacks the pedestal");
	a_vsync_gated: assert property (o_out_valid && o_vsync |-> !ext_mode)
		else $error("vsync passed while the pin is blanking");
	a_sep_no_blank: assert property (o_out_valid && !ext_mode && !blank_ctl[0] |-> !o_enc_blank)
		else $error("blanking seen with separate syncs");
	a_u_gain_zero: assert property (o_out_valid && gain_u == 8'h00 |-> o_u == 10'h000)
		else $error("u nonzero with zero gain");
	a_v_gain_zero: assert property (o_out_valid && gain_v == 8'h00 |-> o_v == 10'h000)
		else $error("v nonzero with zero gain");
endmodule
bind vefe_front_end vefe_front_end_properties u_props (.i_clk, .i_reset_n, .i_ser_clk,
	.i_ser_data, .i_ser_ident, .i_pix_valid, .o_pix_ready, .o_dac_a, .o_dac_b, .o_dac_c,
	.o_u, .o_v, .o_vsync, .o_enc_blank, .o_out_valid, .i_out_ready);

/* bench/test_vefe_front_end.sv */
// self-checking bench for the encoder front end
`timescale 1ns/100ps
`include "vefe_regs.vh"
module test_vefe_front_end;
	logic        i_clk = 0;
	logic        i_reset_n = 0;
	logic        i_ser_clk = 0;
	logic        i_ser_data = 0;
	logic        i_ser_ident = 0;
	logic        i_out_ready = 1;
	logic [7:0]  i_pix_a, i_pix_b, i_pix_c, o_dac_a, o_dac_b, o_dac_c;
	logic        i_hsync, i_vsync, i_pix_valid, o_pix_ready;
	logic        o_hsync, o_vsync, o_enc_blank, o_out_valid, ext;
	logic [9:0]  o_u, o_v;
	logic [11:0] o_chroma;
	logic [61:0] q[$];
	int          err_total = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          yuv, bm, ebd, pd, bw, pk, sec, za, par, lhs, su, sv, hp;
	int          ug = `VEFE_RST_GAIN;
	int          vg = `VEFE_RST_GAIN;
	int          bst = `VEFE_RST_BLANK_START;
	int          bend = `VEFE_RST_BLANK_END;
	vefe_front_end dut (.i_clk, .i_reset_n, .i_ser_clk, .i_ser_data, .i_ser_ident, .i_pix_a,
		.i_pix_b, .i_pix_c, .i_hsync, .i_vsync, .i_pix_valid, .o_pix_ready, .o_dac_a, .o_dac_b,
		.o_dac_c, .o_u, .o_v, .o_chroma, .o_hsync, .o_vsync, .o_enc_blank, .o_out_valid,
		.i_out_ready);
	vefe_pix_source src (.i_clk, .i_ready(o_pix_ready), .o_a(i_pix_a), .o_b(i_pix_b),
		.o_c(i_pix_c), .o_hs(i_hsync), .o_vs(i_vsync), .o_valid(i_pix_valid));
	always #2 i_clk = ~i_clk;
	task automatic final_report();
		if (err_total == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	function automatic int sat(int x, int lim);
		return x >= lim ? lim - 1 : x < -lim ? -lim : x;
	endfunction
	function automatic logic [7:0] dac(int x);
		return ext ? 8'h00 : pd ? 8'(x) : 8'(sat(x + `VEFE_PEDESTAL, 256));
	endfunction
	function automatic int peak(int s, int x);
		int l;
		l = s >>> 6;
		return ((128 + pk) * l >>> 7) + ((-pk) * (x - l) >>> 6);
	endfunction
	// flag bits: enc blank, u/v, chroma are compared only where set
	task automatic chk(input logic [61:0] e);
		logic [58:0] g, m;
		g = {o_dac_a, o_dac_b, o_dac_c, o_hsync, o_vsync, o_enc_blank, o_u, o_v, o_chroma};
		m = {26'h3FFFFFF, e[61], {20{e[60]}}, {12{e[59]}}};
		tests_run++;
		if (((g ^ e[58:0]) & m) !== 59'h0) begin
			err_total++;
			$display("mismatch at %0t: word %h expected %h", $time, g, e[58:0]);
		end
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			$display("mismatch at %0t: timeout", $time);
			final_report();
		end
		if (o_out_valid === 1'b1 && i_out_ready && q.size() > 0) chk(q.pop_front());
		else if (o_out_valid === 1'b1 && i_out_ready) begin
			err_total++;
			$display("mismatch at %0t: word out with nothing expected", $time);
		end
	end
	task automatic wr(input logic [7:0] ad, dt);
		logic [15:0] f;
		f = {ad, dt};
		i_ser_ident = 1;
		cyc(4);
		for (int i = 15; i >= 0; i--) begin
			i_ser_data = f[i];
			cyc(4);
			i_ser_clk = 1;
			cyc(4);
			i_ser_clk = 0;
		end
		cyc(4);
		i_ser_ident = 0;
		i_ser_data = ~i_ser_data;
		cyc(6);
		case (ad)
			`VEFE_ADDR_EMPH_ZERO: za = dt;
			`VEFE_ADDR_CLP_BW: bw = dt[2:0];
			`VEFE_ADDR_CLP_PEAK: pk = int'($signed(dt));
			`VEFE_ADDR_BLUE_GAIN: ug = dt;
			`VEFE_ADDR_RED_GAIN: vg = dt;
			`VEFE_ADDR_OUT_BLANK: {pd, ebd} = {31'h0, dt[1], 31'h0, dt[0]};
			`VEFE_ADDR_IN_SYNC: {bm, yuv} = {31'h0, dt[1] | dt[2], 31'h0, dt[0]};
			`VEFE_ADDR_BLANK_END: bend = dt;
			`VEFE_ADDR_STANDARD: sec = dt[0];
			default: ;
		endcase
	endtask
	task automatic px(input int a, b, c, input logic h, v, input logic [2:0] cf);
		int ub, vr, uu, vv, x, ch, eb, pu, pv;
		if (yuv) begin
			ub = b - 128;
			vr = c - 128;
		end else begin
			ub = (77 * a + 150 * b + 29 * c) >>> 8;
			vr = a - ub;
			ub = c - ub;
		end
		// filter, line parity and position are all taken before this sample updates them
		pu = sat(peak(su, ub), 512);
		pv = sat(peak(sv, vr), 512);
		su += ((ub <<< 6) - su) >>> bw;
		sv += ((vr <<< 6) - sv) >>> bw;
		uu = sat(pu * ug >>> 7, 512);
		vv = sat(pv * vg >>> 7, 512);
		x = par ? pv : sat(-pu, 512);
		ch = sec ? sat(4 * (x - (za * x >>> 7)), 2048) : x;
		ext = bm && v;
		eb = ebd ? (hp >= bst * 8 || hp < bend * 8) : ext;
		par ^= h && !lhs;
		hp = (h && !lhs) ? 0 : (hp < 2047 ? hp + 1 : hp);
		lhs = h;
		q.push_back({cf | {!ebd, 2'b00}, dac(a), dac(b), dac(c), h, !bm && v, eb[0],
			10'(uu), 10'(vv), 12'(ch)});
		src.send(a, b, c, h, v);
	endtask
	task automatic run(input int a, b, c, input logic h, v, input int n, input logic [2:0] cf);
		repeat (n) px(a, b, c, h, v, cf);
		src.idle();
		for (int k = 0; k < 40 && q.size() > 0; k++) cyc(1);
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_reset_n = 1;
		cyc(4);
		run(200, 30, 10, 0, 0, 3, 3'b011);
		run(248, 0, 255, 0, 0, 2, 3'b011);
		wr(`VEFE_ADDR_OUT_BLANK, 8'h02);
		run(248, 0, 5, 0, 0, 2, 3'b011);
		for (int m = 0; m < 4; m++) begin
			wr(`VEFE_ADDR_IN_SYNC, 8'(m << 1));
			run(90, 90, 90, 0, 1, 2, 3'b011);
			run(90, 90, 90, 0, 0, 1, 3'b011);
		end
		wr(`VEFE_ADDR_IN_SYNC, 8'h01);
		run(16, 200, 60, 0, 0, 2, 3'b011);
		wr(`VEFE_ADDR_BLUE_GAIN, 8'h00);
		wr(`VEFE_ADDR_RED_GAIN, 8'h00);
		run(30, 220, 20, 0, 0, 2, 3'b011);
		wr(`VEFE_ADDR_RED_GAIN, 8'h7F);
		i_out_ready = 0;
		fork
			run(60, 120, 180, 0, 0, 10, 3'b011);
		join_none
		cyc(20);
		tests_run++;
		if (o_pix_ready !== 1'b0) begin
			err_total++;
			$display("mismatch at %0t: full buffer did not refuse", $time);
		end
		i_out_ready = 1;
		cyc(40);
		for (int k = 7; k >= 0; k--) begin
			wr(`VEFE_ADDR_CLP_BW, 8'(k));
			run(8, 240, 40 + 20 * k, 0, 0, 2, 3'b011);
		end
		wr(`VEFE_ADDR_CLP_PEAK, 8'hCE);
		run(16, 230, 90, 0, 0, 3, 3'b011);
		wr(`VEFE_ADDR_CLP_PEAK, 8'h00);
		wr(`VEFE_ADDR_OUT_BLANK, 8'h01);
		wr(`VEFE_ADDR_IN_SYNC, 8'h04);
		wr(`VEFE_ADDR_BLANK_END, 8'h01);
		px(50, 90, 70, 0, 0, 3'b011);
		for (int i = 0; i < 12; i++)
			px(50, 90, 70, 1, i > 8, (i inside {[3:6], [10:11]}) ? 3'b111 : 3'b011);
		run(0, 0, 0, 1, 0, 0, 3'b000);
		wr(`VEFE_ADDR_STANDARD, 8'h01);
		wr(`VEFE_ADDR_EMPH_ZERO, 8'h40);
		wr(`VEFE_ADDR_IN_SYNC, 8'h01);
		wr(`VEFE_ADDR_BLUE_GAIN, 8'h40);
		run(100, 168, 208, 0, 0, 12, 3'b010);
		run(100, 168, 208, 0, 0, 4, 3'b011);
		tests_run++;
		if (q.size() != 0) begin
			err_total++;
			$display("mismatch at %0t: %0d expected words never came out", $time, q.size());
		end
		final_report();
	end
endmodule
